// *** rps_consts.vh ***
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define RPS_CLK_HZ 50000000
`define RPS_RTC_START_MS 300
`define RPS_RTC_START_CYC ((`RPS_CLK_HZ / 1000) * `RPS_RTC_START_MS)
`define RPS_PPS_HIGH_MS 200
`define RPS_PPS_HIGH_CYC ((`RPS_CLK_HZ / 1000) * `RPS_PPS_HIGH_MS)
`define RPS_SEC_CYC `RPS_CLK_HZ
`define RPS_GSV_SEC 5
`define RPS_HOT_HOURS 2
`define RPS_HOT_SEC (`RPS_HOT_HOURS * 3600)
`define RPS_PTF_SEC 7200
// ----------------------------------------
// Host port select codes
// ----------------------------------------
`define RPS_HOST_UART 2'h1
`define RPS_HOST_I2C 2'h2
`define RPS_HOST_SPI 2'h0
// ----------------------------------------
// Rate codes
// ----------------------------------------
`define RPS_RATE_NMEA_4800 2'h0
`define RPS_RATE_NMEA_9600 2'h1
`define RPS_RATE_NMEA_38400 2'h2
`define RPS_RATE_BIN_115200 2'h3
`define RPS_UART_DATA_BITS 4'h8
`define RPS_UART_STOP_BITS 2'h1
// ----------------------------------------
// Power management modes
// ----------------------------------------
`define RPS_PM_FULL 3'h0
`define RPS_PM_MICRO 3'h1
`define RPS_PM_ADAPT 3'h2
`define RPS_PM_ASSIST 3'h3
`define RPS_PM_PERIODIC 3'h4
`endif

// *** rps_host_model.sv ***
`timescale 1ns/1ps
module rps_host_model (
  // Clock and request
  input wire ref_clk,
  input wire pulse_req,
  // Toggle pin
  output reg power_toggle
);
  reg [2:0] cnt_q;
  initial begin
    power_toggle = 1'b0;
    cnt_q = 3'h0;
  end
  // Four cycles high, well over what the synchroniser needs
  always @(posedge ref_clk) begin
    if (pulse_req) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    power_toggle <= pulse_req || (cnt_q > 3'h1);
  end
endmodule // rps_host_model

// *** rps_power_seq.v ***
// Summary of operation
// - After supply-on, wait for RTC start (300 ms), then enter hibernate.
// - A toggle pulse in hibernate moves the receiver to operate.
// - A toggle pulse in operate returns to hibernate; pulses alternate.
// - Supply loss clears time, memory and settings; next boot is cold.
// - Boot on linear regulator; switcher only after a host binary command.
// - First session after factory hibernate wakes as a cold start.
// - Hot start allowed if shut down within hours after a valid fix.
// - Micro power mode stays hibernating, waking only to refresh data or on pulse.
// - Adaptive mode follows user duty cycle; goes full power on weak signals.
// - Assisted mode waits for all aiding; honours host cycle criteria.
// - Periodic mode wakes every two hours for a cold-start fix, or on pulse.
// - Time mark output pulses once per second, 200 ms high.
// - Host-select straps sampled at power-up: UART, I2C or SPI slave.
// - Rate straps decode to NMEA 4800/9600/38400 or binary 115200.
// - UART defaults to 8 data bits, no parity, one stop bit.
// - After start-up the rate straps are no longer used.
// - With EEPROM or flash attached, ignore straps; NMEA 4800, changeable later.
// - NMEA mode: RMC, GGA, GSA every second, GSV every five seconds.
// - Binary mode: six fixed messages once per second.
// - Auxiliary port is I2C master or SPI master, never both.
// - Probe auxiliary bus for EEPROM or flash; default I2C for sensors.
`timescale 1ns/1ps
`include "rps_consts.vh"
module rps_power_seq #(
  parameter RTC_START_CYC = `RPS_RTC_START_CYC,
  parameter PPS_HIGH_CYC = `RPS_PPS_HIGH_CYC,
  parameter SEC_CYC = `RPS_SEC_CYC,
  parameter HOT_SEC = `RPS_HOT_SEC,
  parameter PTF_SEC = `RPS_PTF_SEC
) (
  // Clock, enable, supply reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Host pins
  input wire power_toggle,
  input wire host_sel_a,
  input wire host_sel_b,
  input wire host_sel_a_float,
  input wire host_sel_b_float,
  input wire rate_strap_a,
  input wire rate_strap_b,
  // Auxiliary bus probe results
  input wire aux_probe_done,
  input wire aux_eeprom_found,
  input wire aux_flash_found,
  // Navigation engine status and commands
  input wire fix_valid,
  input wire switcher_cmd,
  input wire rate_cmd_valid,
  input wire [1:0] rate_cmd,
  input wire [2:0] pm_mode,
  input wire aiding_complete,
  input wire signal_weak,
  input wire [7:0] duty_on_sec,
  input wire [7:0] duty_period_sec,
  input wire maint_request,
  input wire shutdown_cmd,
  // Power state outputs
  output reg system_on,
  output reg boot_done,
  output reg hot_start_ok,
  output reg cold_start,
  output reg switcher_en,
  // Configuration outputs
  output reg [1:0] host_port_sel,
  output reg [1:0] rate_sel,
  output reg binary_message_protocol,
  output reg [3:0] uart_data_bits,
  output reg uart_parity_en,
  output reg [1:0] uart_stop_bits,
  output reg rate_straps_released,
  output reg aux_is_spi,
  output reg aux_is_i2c,
  // Timing outputs
  output reg time_mark_out,
  output reg msg_fix_tick,
  output reg msg_sats_tick
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [6:0] pin_s;
  rps_sync3 #(.WIDTH(7)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({power_toggle, host_sel_a, host_sel_b, host_sel_a_float, host_sel_b_float,
      rate_strap_a, rate_strap_b}),
    .sync_out(pin_s)
  );
  reg tog_prev_q;
  wire tog_rise = pin_s[6] & ~tog_prev_q;
  // ----------------------------------------
  // Power states
  // ----------------------------------------
  localparam [3:0] ST_RTC = 4'b0001;
  localparam [3:0] ST_CFG = 4'b0010;
  localparam [3:0] ST_HIB = 4'b0100;
  localparam [3:0] ST_OPR = 4'b1000;
  reg [3:0] st_q;
  reg [31:0] cnt_q;
  reg [31:0] sec_cnt_q;
  wire sec_tick = (sec_cnt_q == SEC_CYC - 1);
  reg [15:0] off_sec_q;
  reg [15:0] on_sec_q;
  reg had_fix_q;
  reg fix_at_off_q;
  reg auto_wake_q;
  reg [2:0] gsv_cnt_q;
  wire hot_window = fix_at_off_q && (off_sec_q < HOT_SEC);
  wire pm_sleep_ok = (pm_mode != `RPS_PM_ASSIST) || aiding_complete;
  // Duty-cycle phase end: leaves full power unless signals are weak
  wire duty_off = (pm_mode == `RPS_PM_ADAPT) && !signal_weak && (duty_period_sec != 8'h00)
    && (on_sec_q >= {8'h00, duty_on_sec});
  wire assist_off = (pm_mode == `RPS_PM_ASSIST) && aiding_complete
    && (on_sec_q >= {8'h00, duty_on_sec});
  wire micro_off = (pm_mode == `RPS_PM_MICRO) && auto_wake_q && fix_valid;
  wire periodic_off = (pm_mode == `RPS_PM_PERIODIC) && auto_wake_q && fix_valid;
  // Automatic wake from hibernate
  wire wake_auto = ((pm_mode == `RPS_PM_MICRO) && maint_request)
    || ((pm_mode == `RPS_PM_ADAPT) && (duty_period_sec != 8'h00)
      && (off_sec_q >= {8'h00, duty_period_sec - duty_on_sec}))
    || ((pm_mode == `RPS_PM_ASSIST) && aiding_complete
      && (off_sec_q >= {8'h00, duty_period_sec - duty_on_sec}))
    || ((pm_mode == `RPS_PM_PERIODIC) && (off_sec_q >= PTF_SEC));

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Supply loss restores factory state
      st_q <= ST_RTC;
      cnt_q <= 32'h0000_0000;
      tog_prev_q <= 1'b0;
      system_on <= 1'b0;
      boot_done <= 1'b0;
      hot_start_ok <= 1'b0;
      cold_start <= 1'b1;
      switcher_en <= 1'b0;
      host_port_sel <= `RPS_HOST_SPI;
      rate_sel <= `RPS_RATE_NMEA_4800;
      binary_message_protocol <= 1'b0;
      uart_data_bits <= `RPS_UART_DATA_BITS;
      uart_parity_en <= 1'b0;
      uart_stop_bits <= `RPS_UART_STOP_BITS;
      rate_straps_released <= 1'b0;
      aux_is_spi <= 1'b0;
      aux_is_i2c <= 1'b0;
      off_sec_q <= 16'h0000;
      on_sec_q <= 16'h0000;
      had_fix_q <= 1'b0;
      fix_at_off_q <= 1'b0;
      auto_wake_q <= 1'b0;
    end else if (clk_en) begin
      tog_prev_q <= pin_s[6];
      if (switcher_cmd) begin
        switcher_en <= 1'b1;
      end
      // Later rate change by binary message
      if (rate_cmd_valid && boot_done) begin
        rate_sel <= rate_cmd;
        binary_message_protocol <= (rate_cmd == `RPS_RATE_BIN_115200);
      end
      case (st_q)
        ST_RTC: begin
          cnt_q <= cnt_q + 32'h0000_0001;
          if (cnt_q >= RTC_START_CYC - 1) begin
            st_q <= ST_CFG;
          end
        end
        ST_CFG: begin
          // Probe finishes before straps are decoded
          if (aux_probe_done) begin
            // First strap pulled up, second floating
            if (pin_s[5] && !pin_s[3] && pin_s[2]) begin
              host_port_sel <= `RPS_HOST_UART;
            // First floating, second pulled down
            end else if (pin_s[3] && !pin_s[2] && !pin_s[4]) begin
              host_port_sel <= `RPS_HOST_I2C;
            end else begin
              host_port_sel <= `RPS_HOST_SPI;
            end
            aux_is_spi <= aux_flash_found && !aux_eeprom_found;
            aux_is_i2c <= !(aux_flash_found && !aux_eeprom_found);
            if (aux_eeprom_found || aux_flash_found) begin
              rate_sel <= `RPS_RATE_NMEA_4800;
              binary_message_protocol <= 1'b0;
            end else begin
              rate_sel <= {~pin_s[1], ~pin_s[0]};
              binary_message_protocol <= ~pin_s[1] & ~pin_s[0];
            end
            rate_straps_released <= 1'b1;
            boot_done <= 1'b1;
            st_q <= ST_HIB;
          end
        end
        ST_HIB: begin
          if (sec_tick && off_sec_q != 16'hffff) begin
            off_sec_q <= off_sec_q + 16'h0001;
          end
          if (tog_rise || (wake_auto && pm_mode != `RPS_PM_FULL)) begin
            st_q <= ST_OPR;
            system_on <= 1'b1;
            auto_wake_q <= !tog_rise;
            on_sec_q <= 16'h0000;
            // No fix ever held means a cold start
            cold_start <= !had_fix_q || !(hot_window || pm_mode == `RPS_PM_MICRO);
            hot_start_ok <= had_fix_q && (hot_window || pm_mode == `RPS_PM_MICRO);
          end
        end
        ST_OPR: begin
          if (fix_valid) begin
            had_fix_q <= 1'b1;
          end
          if (sec_tick && on_sec_q != 16'hffff) begin
            on_sec_q <= on_sec_q + 16'h0001;
          end
          if (tog_rise || shutdown_cmd || (pm_sleep_ok && (duty_off || assist_off || micro_off
            || periodic_off))) begin
            st_q <= ST_HIB;
            system_on <= 1'b0;
            fix_at_off_q <= fix_valid || had_fix_q;
            off_sec_q <= 16'h0000;
          end
        end
        default: begin
          st_q <= ST_RTC;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Time mark and message cadence
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_cnt_q <= 32'h0000_0000;
      time_mark_out <= 1'b0;
      msg_fix_tick <= 1'b0;
      msg_sats_tick <= 1'b0;
      gsv_cnt_q <= 3'h0;
    end else if (clk_en) begin
      sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      // Mark runs only while navigating
      time_mark_out <= system_on && (sec_cnt_q < PPS_HIGH_CYC);
      msg_fix_tick <= system_on && sec_tick;
      msg_sats_tick <= system_on && sec_tick && !binary_message_protocol
        && (gsv_cnt_q == `RPS_GSV_SEC - 1);
      if (sec_tick && system_on) begin
        gsv_cnt_q <= (gsv_cnt_q == `RPS_GSV_SEC - 1) ? 3'h0 : gsv_cnt_q + 3'h1;
      end
    end
  end
endmodule // rps_power_seq

// *** rps_power_seq_assertions.sv ***
`timescale 1ns/1ps
module rps_power_seq_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Host and engine inputs
  input wire power_toggle,
  input wire switcher_cmd,
  input wire rate_cmd_valid,
  input wire [2:0] pm_mode,
  // Watched outputs
  input wire system_on,
  input wire boot_done,
  input wire cold_start,
  input wire switcher_en,
  input wire [1:0] rate_sel,
  input wire rate_straps_released,
  input wire [3:0] uart_data_bits,
  input wire uart_parity_en,
  input wire [1:0] uart_stop_bits,
  input wire aux_is_spi,
  input wire aux_is_i2c,
  input wire time_mark_out,
  input wire msg_fix_tick
);
  reg cmd_seen_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Supply loss forgets the command too
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) cmd_seen_q <= 1'b0;
    else if (switcher_cmd) cmd_seen_q <= 1'b1;
  end
  a_uart_frame_fixed: assert property (uart_data_bits == 4'h8 && !uart_parity_en && uart_stop_bits == 2'h1)
    else $error("uart frame not 8N1");
  a_aux_one_master: assert property (!(aux_is_spi && aux_is_i2c))
    else $error("aux port is both masters");
  a_boot_stays_off: assert property (!boot_done |-> !system_on && cold_start)
    else $error("operate or warm before boot ends");
  a_switch_after_cmd: assert property (switcher_en |-> cmd_seen_q)
    else $error("switcher on without command");
  a_rate_held: assert property ($past(rate_straps_released) && !$past(rate_cmd_valid) |-> $stable(rate_sel))
    else $error("rate changed after straps released");
  // Window allows for the three-stage pin synchroniser
  a_wake_on_pulse: assert property (boot_done && !system_on && pm_mode == 3'h0 && $rose(power_toggle)
    |-> ##[2:8] system_on)
    else $error("no wake after toggle pulse");
  a_sleep_on_pulse: assert property (system_on && pm_mode == 3'h0 && $rose(power_toggle)
    |-> ##[2:8] !system_on)
    else $error("no sleep after toggle pulse");
  a_mark_needs_on: assert property (time_mark_out |-> system_on || $past(system_on))
    else $error("time mark while hibernating");
  // A frozen clock holds the tick, so only enabled cycles count
  a_tick_one_cycle: assert property (msg_fix_tick && clk_en |=> !msg_fix_tick)
    else $error("fix tick wider than one cycle");
endmodule // rps_power_seq_chk
bind rps_power_seq rps_power_seq_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
  .power_toggle(power_toggle),
  .switcher_cmd(switcher_cmd), .rate_cmd_valid(rate_cmd_valid), .pm_mode(pm_mode), .system_on(system_on),
  .boot_done(boot_done), .cold_start(cold_start), .switcher_en(switcher_en), .rate_sel(rate_sel),
  .rate_straps_released(rate_straps_released), .uart_data_bits(uart_data_bits), .uart_parity_en(uart_parity_en),
  .uart_stop_bits(uart_stop_bits), .aux_is_spi(aux_is_spi), .aux_is_i2c(aux_is_i2c),
  .time_mark_out(time_mark_out), .msg_fix_tick(msg_fix_tick));

// *** rps_power_seq_tb_top.sv ***
`timescale 1ns/1ps
module rps_power_seq_tb_top;
  localparam [71:0] TBL = 72'hf4_1886_5c83_4d36_1092;
  reg ref_clk, rst_b, clk_en, pulse_req, host_sel_a, host_sel_b, host_sel_a_float, host_sel_b_float;
  reg rate_strap_a, rate_strap_b, aux_probe_done, aux_eeprom_found, aux_flash_found, fix_valid;
  reg switcher_cmd, rate_cmd_valid, shutdown_cmd;
  reg aiding_complete, signal_weak, maint_request;
  reg [7:0] duty_on_sec, duty_period_sec;
  reg [1:0] rate_cmd;
  reg [2:0] pm_mode;
  reg [11:0] e;
  reg [7:0] nm, nf, ns;
  integer i, err_count, compares, cycles;
  wire power_toggle, system_on, boot_done, hot_start_ok, cold_start, switcher_en, binary_message_protocol;
  wire aux_is_spi, aux_is_i2c, time_mark_out, msg_fix_tick, msg_sats_tick;
  wire [1:0] host_port_sel, rate_sel, uart_stop_bits;
  wire [3:0] uart_data_bits;
  wire uart_parity_en, rate_straps_released;
  rps_host_model i_host (.ref_clk, .pulse_req, .power_toggle);
  rps_power_seq #(.RTC_START_CYC(20), .PPS_HIGH_CYC(4), .SEC_CYC(10), .HOT_SEC(3), .PTF_SEC(5)) i_dut (
    .ref_clk, .rst_b, .clk_en, .power_toggle, .host_sel_a, .host_sel_b, .host_sel_a_float, .host_sel_b_float,
    .rate_strap_a, .rate_strap_b, .aux_probe_done, .aux_eeprom_found, .aux_flash_found, .fix_valid,
    .switcher_cmd, .rate_cmd_valid, .rate_cmd, .pm_mode, .aiding_complete, .signal_weak,
    .duty_on_sec, .duty_period_sec, .maint_request, .shutdown_cmd, .system_on, .boot_done,
    .hot_start_ok, .cold_start, .switcher_en, .host_port_sel, .rate_sel, .binary_message_protocol,
    .uart_data_bits, .uart_parity_en, .uart_stop_bits, .rate_straps_released, .aux_is_spi, .aux_is_i2c,
    .time_mark_out, .msg_fix_tick, .msg_sats_tick);
  // ----
  // Tasks
  // ----
  task step(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  task chk(input string nm_s, input [7:0] exp, input [7:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %s expected %h seen %h", nm_s, exp, got);
      end
    end
  endtask
  task pulse;
    begin
      pulse_req = 1'b1;
      step(1);
      pulse_req = 1'b0;
      step(11);
    end
  endtask
  // Bounded wait for the operate indication to reach a level
  task wait_on(input v, input integer n);
    begin
      i = 0;
      while (system_on !== v && i < n) begin
        step(1);
        i = i + 1;
      end
    end
  endtask
  // Sums over whole periods, so the phase of the window does not matter
  task count(input integer n);
    begin
      nm = 8'h00;
      nf = 8'h00;
      ns = 8'h00;
      repeat (n) begin
        step(1);
        nm = nm + time_mark_out;
        nf = nf + msg_fix_tick;
        ns = ns + msg_sats_tick;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    {rst_b, clk_en, pulse_req, host_sel_a, host_sel_b, host_sel_a_float, host_sel_b_float} = 7'h20;
    {aiding_complete, signal_weak, maint_request} = 3'h0;
    duty_on_sec = 8'h01;
    duty_period_sec = 8'h03;
    {rate_strap_a, rate_strap_b, aux_eeprom_found, aux_flash_found, fix_valid} = 5'h00;
    {switcher_cmd, rate_cmd_valid, shutdown_cmd, rate_cmd, pm_mode} = 8'h00;
    aux_probe_done = 1'b1;
    err_count = 0;
    compares = 0;
    cycles = 0;
    for (i = 0; i < 6; i = i + 1) begin
      e = TBL[71-12*i -: 12];
      {rate_strap_a, rate_strap_b, host_sel_a, host_sel_b, host_sel_a_float, host_sel_b_float} = e[11:6];
      {aux_eeprom_found, aux_flash_found} = e[5:4];
      aux_probe_done = 1'b0;
      rst_b = 1'b0;
      step(4);
      rst_b = 1'b1;
      step(15);
      chk("boot_done early", 1'h0, boot_done);
      chk("straps early", 1'h0, rate_straps_released);
      step(10);
      chk("probe wait", 1'h0, boot_done);
      aux_probe_done = 1'b1;
      step(10);
      chk("boot_done", 1'h1, boot_done);
      chk("straps released", 1'h1, rate_straps_released);
      chk("uart_data_bits", 8'h08, uart_data_bits);
      chk("uart_parity_en", 1'h0, uart_parity_en);
      chk("uart_stop_bits", 2'h1, uart_stop_bits);
      chk("system_on", 1'h0, system_on);
      chk("cold_start", 1'h1, cold_start);
      chk("host_port_sel", e[1:0], host_port_sel);
      chk("rate_sel", e[3:2], rate_sel);
      chk("binary_proto", &e[3:2], binary_message_protocol);
      chk("aux_is_spi", e[4] && !e[5], aux_is_spi);
      chk("aux_is_i2c", !(e[4] && !e[5]), aux_is_i2c);
      {rate_strap_a, rate_strap_b} = ~e[11:10];
      step(6);
      chk("rate_sel held", e[3:2], rate_sel);
      $display("boot case %0d done", i);
    end
    pulse;
    chk("system_on", 1'h1, system_on);
    count(50);
    chk("mark cycles", 8'h14, nm);
    chk("fix ticks", 8'h05, nf);
    chk("sats ticks", 8'h01, ns);
    clk_en = 1'b0;
    count(30);
    clk_en = 1'b1;
    chk("frozen ticks", 8'h00, nf);
    chk("switcher_en", 1'h0, switcher_en);
    switcher_cmd = 1'b1;
    step(1);
    switcher_cmd = 1'b0;
    rate_cmd = 2'h3;
    rate_cmd_valid = 1'b1;
    step(1);
    rate_cmd_valid = 1'b0;
    step(2);
    chk("switcher_en", 1'h1, switcher_en);
    chk("rate_sel cmd", 2'h3, rate_sel);
    chk("binary cmd", 1'h1, binary_message_protocol);
    $display("operate test done");
    fix_valid = 1'b1;
    step(2);
    pulse;
    chk("system_on", 1'h0, system_on);
    fix_valid = 1'b0;
    pulse;
    chk("system_on again", 1'h1, system_on);
    chk("hot_start_ok", 1'h1, hot_start_ok);
    chk("cold_start warm", 1'h0, cold_start);
    shutdown_cmd = 1'b1;
    step(1);
    shutdown_cmd = 1'b0;
    step(4);
    chk("shutdown", 1'h0, system_on);
    step(40);
    pulse;
    chk("system_on late", 1'h1, system_on);
    chk("hot expired", 1'h0, hot_start_ok);
    chk("cold_start late", 1'h1, cold_start);
    count(50);
    chk("bin fix ticks", 8'h05, nf);
    chk("bin sats ticks", 8'h00, ns);
    pulse;
    chk("system_on off", 1'h0, system_on);
    $display("hot start test done");
    pm_mode = 3'h4;
    wait_on(1'b1, 80);
    chk("periodic wake", 1'h1, system_on);
    fix_valid = 1'b1;
    wait_on(1'b0, 8);
    chk("periodic sleep", 1'h0, system_on);
    $display("periodic test done");
    pm_mode = 3'h1;
    fix_valid = 1'b0;
    maint_request = 1'b1;
    wait_on(1'b1, 8);
    maint_request = 1'b0;
    chk("micro wake", 1'h1, system_on);
    chk("micro hot", 1'h1, hot_start_ok);
    fix_valid = 1'b1;
    wait_on(1'b0, 8);
    chk("micro sleep", 1'h0, system_on);
    pm_mode = 3'h2;
    fix_valid = 1'b0;
    wait_on(1'b1, 40);
    chk("adaptive wake", 1'h1, system_on);
    // Weak signals hold full power past the on phase
    signal_weak = 1'b1;
    step(30);
    chk("weak stays on", 1'h1, system_on);
    signal_weak = 1'b0;
    wait_on(1'b0, 4);
    chk("adaptive sleep", 1'h0, system_on);
    pm_mode = 3'h3;
    step(50);
    chk("assist no aid", 1'h0, system_on);
    aiding_complete = 1'b1;
    wait_on(1'b1, 40);
    chk("assist wake", 1'h1, system_on);
    wait_on(1'b0, 40);
    chk("assist sleep", 1'h0, system_on);
    $display("power mode test done");
    print_verdict;
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
endmodule // rps_power_seq_tb_top

// *** rps_sync3.v ***
`timescale 1ns/1ps
module rps_sync3 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (clk_en) begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // Change accepted only when second and third agree
          if (s2_q[gi] == s3_q[gi]) begin
            sync_out[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
endmodule // rps_sync3
